// ### dv/sfs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sfs_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sclk,
  input wire logic chip_select_bar,
  input wire logic mosi,
  input wire logic miso
);
  logic       sclk_reg;
  logic [4:0] rise_reg;

  // Rise count inside the frame; cleared whenever select is released
  always_ff @(posedge clk) begin
    sclk_reg <= sclk;
    if (rst || chip_select_bar)
      rise_reg <= 5'h00;
    else if (sclk && !sclk_reg)
      rise_reg <= rise_reg + 5'h01;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence sel_start;
    $fell(chip_select_bar);
  endsequence
  sequence sel_end;
    $rose(chip_select_bar);
  endsequence

  idle_miso_a: assert property (chip_select_bar && $past(chip_select_bar) &&
    $past(chip_select_bar, 2) |-> !miso) else $error("miso not low while deselected");
  idle_sclk_a: assert property (chip_select_bar |-> !sclk)
    else $error("sclk high while deselected");
  sel_quiet_a: assert property (sel_start |-> !sclk[*8])
    else $error("sclk not idle after select");
  high_phase_a: assert property ($rose(sclk) |-> sclk[*8])
    else $error("sclk high phase too short");
  low_phase_a: assert property ($fell(sclk) && !chip_select_bar |-> !sclk[*8])
    else $error("sclk low phase too short");
  miso_edge_a: assert property ($changed(miso) && !chip_select_bar |-> sclk)
    else $error("miso changed outside high phase");
  upper_zero_a: assert property ($fell(sclk) && rise_reg <= 5'h08 |-> !miso)
    else $error("response upper byte not zero");
  frame_len_a: assert property (sel_end |-> rise_reg == 5'h10)
    else $error("frame without sixteen rises");
  frame_span_a: assert property (sel_start |-> ##[320:340] sel_end)
    else $error("frame length out of range");
  access_bit_a: assert property ($rose(sclk) && rise_reg == 5'h07 |-> mosi)
    else $error("access bit not high");
  tail_zero_a: assert property ($rose(sclk) && rise_reg >= 5'h09 |-> !mosi)
    else $error("command tail not zero");
endmodule
`default_nettype wire

// ### dv/spi_flag_status_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spi_flag_status_readout_tb;
  logic        clk;
  logic        rst;
  logic        start;
  logic        byte_sel;
  logic        busy;
  logic        done;
  logic        f_done;
  logic        f_abort;
  logic        f_done_b;
  logic        f_abort_a;
  logic [15:0] can_f2;
  logic [15:0] io_f2;
  logic [1:0]  code;
  logic [4:0]  addr;
  logic [7:0]  resp;
  logic [15:0] reg_ev, reg_pr, io_ev, io_pr, reg_f, can_f, io_f, reg_f2;
  logic [7:0]  can_ev, can_pr, rt_can, rt_io;
  logic [5:0]  w_ev, w_pr;
  logic [1:0]  s_ev, s_pr;
  int          n_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n_done = 0;
  int          n_abort = 0;

  sfs_spi_if spi ();
  // Second link is driven by the bench itself to cut one frame short and to send one full frame
  sfs_spi_if spi2 ();

  sfs_device #(.DEVICE_ID(8'h3C)) i_sfs_device (.clk(clk), .rst(rst), .spi(spi.device),
    .reg_fail_event(reg_ev), .reg_fail_present(reg_pr), .can_fail_event(can_ev),
    .can_fail_present(can_pr), .can_wire_event(w_ev), .can_wire_present(w_pr),
    .can_summary_event(s_ev), .can_summary_present(s_pr), .io_fail_event(io_ev),
    .io_fail_present(io_pr), .can_rt_state(rt_can), .io_rt_level(rt_io), .reg_flags(reg_f),
    .can_flags(can_f), .io_flags(io_f), .frame_done(f_done), .frame_abort(f_abort_a));
  sfs_device #(.DEVICE_ID(8'h3C)) i_sfs_device_b (.clk(clk), .rst(rst), .spi(spi2.device),
    .reg_fail_event(reg_ev), .reg_fail_present(reg_pr), .can_fail_event(can_ev),
    .can_fail_present(can_pr), .can_wire_event(w_ev), .can_wire_present(w_pr),
    .can_summary_event(s_ev), .can_summary_present(s_pr), .io_fail_event(io_ev),
    .io_fail_present(io_pr), .can_rt_state(rt_can), .io_rt_level(rt_io), .reg_flags(reg_f2),
    .can_flags(can_f2), .io_flags(io_f2), .frame_done(f_done_b), .frame_abort(f_abort));
  sfs_host i_sfs_host (.clk(clk), .rst(rst), .spi(spi.host), .start(start), .code(code),
    .addr(addr), .byte_sel(byte_sel), .busy(busy), .done(done), .resp_byte(resp));
  sfs_chk i_sfs_chk (.clk(clk), .rst(rst), .sclk(spi.sclk),
    .chip_select_bar(spi.chip_select_bar), .mosi(spi.mosi), .miso(spi.miso));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (f_done || f_done_b) n_done <= n_done + 1;
    if (f_abort || f_abort_a) n_abort <= n_abort + 1;
    if (cycles == 12000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report;
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(logic [1:0] c, logic [4:0] a, logic b, logic [7:0] exp);
    @(posedge clk);
    start <= 1'b1;
    code <= c;
    addr <= a;
    byte_sel <= b;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    check("busy", {15'h0000, busy}, 16'h0001);
    repeat (400) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    check("done", {15'h0000, done}, 16'h0001);
    check("busy", {15'h0000, busy}, 16'h0000);
    check("resp_byte", {8'h00, resp}, {8'h00, exp});
    // Clear lands a couple of edges after select rises
    repeat (4) @(negedge clk);
  endtask

  task automatic fire(logic [15:0] r, logic [15:0] i, logic [7:0] c, logic [5:0] w,
                      logic [1:0] s);
    @(posedge clk);
    reg_ev <= r;
    io_ev <= i;
    can_ev <= c;
    w_ev <= w;
    s_ev <= s;
    @(posedge clk);
    reg_ev <= 16'h0000;
    io_ev <= 16'h0000;
    can_ev <= 8'h00;
    w_ev <= 6'h00;
    s_ev <= 2'h0;
    repeat (2) @(negedge clk);
  endtask

  task automatic bang(logic [15:0] w, int n);
    @(posedge clk);
    spi2.chip_select_bar <= 1'b0;
    for (int k = 0; k < n; k++) begin
      spi2.mosi <= w[15-k];
      repeat (4) @(posedge clk);
      spi2.sclk <= 1'b1;
      repeat (4) @(posedge clk);
      spi2.sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    spi2.chip_select_bar <= 1'b1;
    spi2.mosi <= 1'b0;
    repeat (4) @(negedge clk);
  endtask

  initial begin
    rst = 1'b1;
    start = 1'b0;
    code = 2'h0;
    addr = 5'h00;
    byte_sel = 1'b0;
    {reg_ev, reg_pr, io_ev, io_pr} = 64'h0000_0000_0000_0000;
    {can_ev, can_pr, w_ev, w_pr, s_ev, s_pr} = 32'h0000_0000;
    rt_can = 8'hC3;
    rt_io = 8'h96;
    spi2.sclk = 1'b0;
    spi2.chip_select_bar = 1'b1;
    spi2.mosi = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    reg_pr <= 16'h0F00;
    @(negedge clk);
    check("reg_flags", reg_f, 16'h0000);
    fire(16'hA55A, 16'h1234, 8'h81, 6'h2D, 2'h2);
    check("reg_flags", reg_f, 16'hA55A);
    check("can_flags", can_f, 16'hAD81);
    check("io_flags", io_f, 16'h1234);
    rd(2'h3, 5'h0F, 1'b0, 8'h5A);
    check("reg_flags", reg_f, 16'hA500);
    rd(2'h3, 5'h0F, 1'b1, 8'hA5);
    check("reg_flags", reg_f, 16'h0500);
    bang(16'hDF00, 8);
    check("abort_count", n_abort[15:0], 16'h0001);
    check("reg_flags_b", reg_f2, 16'hA55A);
    bang(16'hDF00, 16);
    check("reg_flags_b", reg_f2, 16'hA500);
    check("can_flags_b", can_f2, 16'hAD81);
    check("io_flags_b", io_f2, 16'h1234);
    rd(2'h0, 5'h10, 1'b1, 8'hC3);
    rd(2'h0, 5'h11, 1'b1, 8'h96);
    rd(2'h0, 5'h12, 1'b1, 8'h3C);
    rd(2'h0, 5'h11, 1'b0, 8'h00);
    rd(2'h1, 5'h11, 1'b0, 8'h00);
    rd(2'h2, 5'h11, 1'b0, 8'h00);
    rd(2'h3, 5'h13, 1'b0, 8'h00);
    check("io_flags", io_f, 16'h1234);
    check("can_flags", can_f, 16'hAD81);
    rd(2'h3, 5'h10, 1'b1, 8'hAD);
    rd(2'h3, 5'h10, 1'b0, 8'h81);
    check("can_flags", can_f, 16'h0000);
    rd(2'h3, 5'h11, 1'b0, 8'h34);
    check("io_flags", io_f, 16'h1200);
    rd(2'h3, 5'h0F, 1'b1, 8'h05);
    check("reg_flags", reg_f, 16'h0500);
    @(posedge clk);
    reg_pr <= 16'h0000;
    rd(2'h3, 5'h0F, 1'b1, 8'h05);
    check("reg_flags", reg_f, 16'h0000);
    // Fourteen host frames plus one clean bench frame on the second link
    check("frame_count", n_done[15:0], 16'h000F);
    check("abort_count", n_abort[15:0], 16'h0001);
    final_report();
  end
endmodule
`default_nettype wire

// ### src/sfs_device.sv
// Notes on behaviour
// [RULE1] Code 11 in bits 15..14 reads failure flags
// [RULE2] Code 00 reads real-time state or identification
// [RULE3] Bits 13..9 carry the five-bit register address
// [RULE4] Host sets bit 8 high in reads
// [RULE5] No parity check on read commands
// [RULE6] Bit 7 picks byte; bits 6..0 zero
// [RULE7] Selected byte is low response byte
// [RULE8] Failure event sets its flag any time
// [RULE9] Read clears flag only if failure gone
// [RULE10] CAN byte two holds six wire faults
// [RULE11] Flags, I/O levels, identification all readable
// [RULE12] Status reads never touch latched flags
// [RULE13] Clear only after full frame, select released
`timescale 1ns/1ps
`default_nettype none
module sfs_device #(
  // Arbitrary identification value
  parameter logic [7:0] DEVICE_ID = 8'h5A
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Serial link
  sfs_spi_if.device        spi,
  // Regulator failure sources
  input  wire logic [15:0] reg_fail_event,
  input  wire logic [15:0] reg_fail_present,
  // CAN failure sources, low byte
  input  wire logic [7:0]  can_fail_event,
  input  wire logic [7:0]  can_fail_present,
  // CAN wire faults: CANL bat, vdd, gnd, CANH bat, vdd, gnd
  input  wire logic [5:0]  can_wire_event,
  input  wire logic [5:0]  can_wire_present,
  // CAN summaries: bit 1 is bus_fault_summary_a
  input  wire logic [1:0]  can_summary_event,
  input  wire logic [1:0]  can_summary_present,
  // I/O failure sources
  input  wire logic [15:0] io_fail_event,
  input  wire logic [15:0] io_fail_present,
  // Real-time state
  input  wire logic [7:0]  can_rt_state,
  input  wire logic [7:0]  io_rt_level,
  // Flag view
  output logic      [15:0] reg_flags,
  output logic      [15:0] can_flags,
  output logic      [15:0] io_flags,
  // Frame outcome
  output logic             frame_done,
  output logic             frame_abort
);
  logic        sclk_prev_reg;
  logic        sclk_prev_next;
  logic        cs_prev_reg;
  logic        cs_prev_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_next;
  logic [15:0] rx_reg;
  logic [15:0] rx_next;
  logic [7:0]  resp_reg;
  logic [7:0]  resp_next;
  logic        miso_reg;
  logic        miso_next;
  logic        done_reg;
  logic        done_next;
  logic        abort_reg;
  logic        abort_next;

  logic        sclk_rise;
  logic        cs_rise;
  logic        frame_ok;
  logic [15:0] sel_word;
  logic [7:0]  sel_byte;
  logic [15:0] evt   [sfs_pkg::NGROUPS];
  logic [15:0] pres  [sfs_pkg::NGROUPS];
  logic [15:0] clr   [sfs_pkg::NGROUPS];
  logic [15:0] flags [sfs_pkg::NGROUPS];

  assign sclk_rise = spi.sclk & ~sclk_prev_reg;
  assign cs_rise   = spi.chip_select_bar & ~cs_prev_reg;
  assign frame_ok  = cs_rise && (cnt_reg == sfs_pkg::FRAME_BITS); // [RULE13]

  // CAN byte two places the wire faults under the two summaries
  assign evt[0]  = reg_fail_event;
  assign pres[0] = reg_fail_present;
  assign evt[1]  = {can_summary_event, can_wire_event, can_fail_event}; // [RULE10]
  assign pres[1] = {can_summary_present, can_wire_present, can_fail_present}; // [RULE10]
  assign evt[2]  = io_fail_event;
  assign pres[2] = io_fail_present;

  for (genvar g = 0; g < sfs_pkg::NGROUPS; g++) begin : g_grp
    sfs_flag_group u_grp (
      .clk      (clk),
      .rst      (rst),
      .event_in (evt[g]),
      .present  (pres[g]),
      .clear_req(clr[g]),
      .flags    (flags[g])
    );
  end

  // Command as known when bit 7 arrives; bits below it are not needed
  assign sel_word = {rx_reg[7:0], spi.mosi, sfs_pkg::TAIL_ZERO};

  // Readout decode; bit 8 is not parity-checked and only marks the access
  always_comb begin
    logic [4:0] a;
    logic [1:0] gi;
    logic [15:0] fw;
    a  = sel_word[sfs_pkg::ADDR_HI:sfs_pkg::ADDR_LO]; // [RULE3] [RULE5]
    gi = 2'(a - sfs_pkg::ADDR_REG);
    fw = sfs_pkg::FLAGS_RESET;
    sel_byte = sfs_pkg::EMPTY_BYTE;
    if (a >= sfs_pkg::ADDR_REG && a <= sfs_pkg::ADDR_IO) begin
      fw = flags[gi];
    end
    case (sel_word[sfs_pkg::CODE_HI:sfs_pkg::CODE_LO])
      sfs_pkg::CMD_FLAGS: begin
        sel_byte = sel_word[sfs_pkg::BYTE_BIT] ? fw[15:8] : fw[7:0]; // [RULE1] [RULE11]
      end
      sfs_pkg::CMD_STATUS: begin
        // Real-time bytes sit in the upper byte select only
        if (sel_word[sfs_pkg::BYTE_BIT]) begin
          case (a)
            sfs_pkg::ADDR_CAN: sel_byte = can_rt_state; // [RULE2]
            sfs_pkg::ADDR_IO:  sel_byte = io_rt_level;  // [RULE11]
            sfs_pkg::ADDR_ID:  sel_byte = DEVICE_ID;    // [RULE11]
            default:           sel_byte = sfs_pkg::EMPTY_BYTE;
          endcase
        end
      end
      default: sel_byte = sfs_pkg::EMPTY_BYTE;
    endcase
  end

  // Clear masks, applied only on a clean frame end of a flag read
  always_comb begin
    logic [4:0] a;
    a = rx_reg[sfs_pkg::ADDR_HI:sfs_pkg::ADDR_LO];
    for (int g = 0; g < sfs_pkg::NGROUPS; g++) begin
      clr[g] = sfs_pkg::FLAGS_RESET;
      if (frame_ok
          && rx_reg[sfs_pkg::CODE_HI:sfs_pkg::CODE_LO] == sfs_pkg::CMD_FLAGS // [RULE12]
          && a == 5'(sfs_pkg::ADDR_REG + 5'(g))) begin
        clr[g] = rx_reg[sfs_pkg::BYTE_BIT] ? sfs_pkg::HIGH_BYTE_MASK
                                           : sfs_pkg::LOW_BYTE_MASK; // [RULE9] [RULE13]
      end
    end
  end

  // Shift engine: sample mosi and present miso on the same sclk rise,
  // so the byte select in bit 7 is known before response bit 7 goes out
  always_comb begin
    sclk_prev_next = spi.sclk;
    cs_prev_next   = spi.chip_select_bar;
    cnt_next       = cnt_reg;
    rx_next        = rx_reg;
    resp_next      = resp_reg;
    miso_next      = miso_reg;
    done_next      = frame_ok;
    abort_next     = cs_rise && !frame_ok;
    if (spi.chip_select_bar) begin
      cnt_next  = '0;
      miso_next = 1'b0;
    end else if (sclk_rise && cnt_reg != sfs_pkg::FRAME_OVER) begin
      cnt_next = cnt_reg + sfs_pkg::COUNT_ONE;
      if (cnt_reg < sfs_pkg::FRAME_BITS) begin
        rx_next = {rx_reg[14:0], spi.mosi};
      end
      if (cnt_reg == sfs_pkg::SELECT_COUNT) begin
        resp_next = sel_byte;
        miso_next = sel_byte[7]; // [RULE7]
      end else if (cnt_reg > sfs_pkg::SELECT_COUNT && cnt_reg < sfs_pkg::FRAME_BITS) begin
        miso_next = resp_reg[3'(sfs_pkg::LAST_BIT_IDX - cnt_reg)]; // [RULE7]
      end else begin
        miso_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
      cnt_reg       <= '0;
      rx_reg        <= '0;
      resp_reg      <= '0;
      miso_reg      <= 1'b0;
      done_reg      <= 1'b0;
      abort_reg     <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_prev_next;
      cs_prev_reg   <= cs_prev_next;
      cnt_reg       <= cnt_next;
      rx_reg        <= rx_next;
      resp_reg      <= resp_next;
      miso_reg      <= miso_next;
      done_reg      <= done_next;
      abort_reg     <= abort_next;
    end
  end

  assign spi.miso    = miso_reg;
  assign reg_flags   = flags[0];
  assign can_flags   = flags[1];
  assign io_flags    = flags[2];
  assign frame_done  = done_reg;
  assign frame_abort = abort_reg;
endmodule
`default_nettype wire

// ### src/sfs_flag_group.sv
`timescale 1ns/1ps
`default_nettype none
module sfs_flag_group (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Failure sources
  input  wire logic [15:0] event_in,
  input  wire logic [15:0] present,
  // Clear from a completed read
  input  wire logic [15:0] clear_req,
  // Latched flags
  output logic      [15:0] flags
);
  logic [15:0] flags_reg;
  logic [15:0] flags_next;

  always_comb begin
    // A still-present failure survives the read; a new event beats the clear
    flags_next = (flags_reg & ~(clear_req & ~present)) | event_in; // [RULE8] [RULE9]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= sfs_pkg::FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;
endmodule
`default_nettype wire

// ### src/sfs_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfs_host (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial link
  sfs_spi_if.host         spi,
  // Read request
  input  wire logic       start,
  input  wire logic [1:0] code,
  input  wire logic [4:0] addr,
  input  wire logic       byte_sel,
  // Read result
  output logic            busy,
  output logic            done,
  output logic [7:0]      resp_byte
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TRAIL} sfs_hst_type;

  sfs_hst_type state_reg;
  sfs_hst_type state_next;
  logic [4:0]  div_reg;
  logic [4:0]  div_next;
  logic [4:0]  bit_reg;
  logic [4:0]  bit_next;
  logic [15:0] tx_reg;
  logic [15:0] tx_next;
  logic [15:0] rx_reg;
  logic [15:0] rx_next;
  logic        sclk_reg;
  logic        sclk_next;
  logic        cs_reg;
  logic        cs_next;
  logic        done_reg;
  logic        done_next;
  logic [7:0]  resp_reg;
  logic [7:0]  resp_next;
  logic        half_up;

  assign half_up = (div_reg == sfs_pkg::HALF_LAST);

  always_comb begin
    state_next = state_reg;
    div_next   = half_up ? '0 : div_reg + sfs_pkg::COUNT_ONE;
    bit_next   = bit_reg;
    tx_next    = tx_reg;
    rx_next    = rx_reg;
    sclk_next  = sclk_reg;
    cs_next    = cs_reg;
    done_next  = 1'b0;
    resp_next  = resp_reg;
    case (state_reg)
      ST_IDLE: begin
        div_next = '0;
        if (start) begin
          // Bit 8 is always set and bits 6..0 are sent as zero
          tx_next = {code, addr, sfs_pkg::ACCESS_MARK, byte_sel, sfs_pkg::TAIL_ZERO}; // [RULE4] [RULE6]
          bit_next   = '0;
          cs_next    = 1'b0;
          state_next = ST_LOW;
        end
      end
      ST_LOW: begin
        if (half_up) begin
          sclk_next  = 1'b1;
          state_next = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (half_up) begin
          // Device presents miso on the rise, so it is settled here
          sclk_next = 1'b0;
          rx_next   = {rx_reg[14:0], spi.miso};
          tx_next   = {tx_reg[14:0], 1'b0};
          bit_next  = bit_reg + sfs_pkg::COUNT_ONE;
          state_next = (bit_reg == sfs_pkg::LAST_BIT_IDX) ? ST_TRAIL : ST_LOW;
        end
      end
      ST_TRAIL: begin
        if (half_up) begin
          cs_next    = 1'b1;
          done_next  = 1'b1;
          resp_next  = rx_reg[7:0];
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      div_reg   <= '0;
      bit_reg   <= '0;
      tx_reg    <= '0;
      rx_reg    <= '0;
      sclk_reg  <= 1'b0;
      cs_reg    <= 1'b1;
      done_reg  <= 1'b0;
      resp_reg  <= '0;
    end else begin
      state_reg <= state_next;
      div_reg   <= div_next;
      bit_reg   <= bit_next;
      tx_reg    <= tx_next;
      rx_reg    <= rx_next;
      sclk_reg  <= sclk_next;
      cs_reg    <= cs_next;
      done_reg  <= done_next;
      resp_reg  <= resp_next;
    end
  end

  assign spi.sclk            = sclk_reg;
  assign spi.chip_select_bar = cs_reg;
  assign spi.mosi            = tx_reg[15];
  assign busy                = ~cs_reg;
  assign done                = done_reg;
  assign resp_byte           = resp_reg;
endmodule
`default_nettype wire

// ### src/sfs_pkg.sv
`default_nettype none
package sfs_pkg;
  // Command codes in bits 15..14
  localparam logic [1:0] CMD_FLAGS  = 2'h3;
  localparam logic [1:0] CMD_STATUS = 2'h0;
  // Command word field positions
  localparam int CODE_HI    = 15;
  localparam int CODE_LO    = 14;
  localparam int ADDR_HI    = 13;
  localparam int ADDR_LO    = 9;
  localparam int ACCESS_BIT = 8;
  localparam int BYTE_BIT   = 7;
  localparam logic       ACCESS_MARK = 1'h1;
  localparam logic [6:0] TAIL_ZERO   = 7'h00;
  // Register addresses
  localparam logic [4:0] ADDR_REG = 5'h0F;
  localparam logic [4:0] ADDR_CAN = 5'h10;
  localparam logic [4:0] ADDR_IO  = 5'h11;
  localparam logic [4:0] ADDR_ID  = 5'h12;
  localparam int NGROUPS = 3;
  // Frame bit counting
  localparam logic [4:0] FRAME_BITS   = 5'h10;
  localparam logic [4:0] FRAME_OVER   = 5'h11;
  localparam logic [4:0] SELECT_COUNT = 5'h08;
  localparam logic [4:0] LAST_BIT_IDX = 5'h0F;
  localparam logic [4:0] COUNT_ONE    = 5'h01;
  localparam logic [15:0] LOW_BYTE_MASK  = 16'h00FF;
  localparam logic [15:0] HIGH_BYTE_MASK = 16'hFF00;
  localparam logic [7:0]  EMPTY_BYTE     = 8'h00;
  localparam logic [15:0] FLAGS_RESET    = 16'h0000;
  // Serial clock timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS  = 500;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] HALF_LAST = 5'(SCLK_HALF_CYC - 1);
endpackage
`default_nettype wire

// ### src/sfs_spi_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfs_spi_if;
  logic sclk;
  logic chip_select_bar;
  logic mosi;
  logic miso;

  modport device (
    input  sclk,
    input  chip_select_bar,
    input  mosi,
    output miso
  );

  modport host (
    output sclk,
    output chip_select_bar,
    output mosi,
    input  miso
  );
endinterface
`default_nettype wire
